// ==== hdl/sdc_divider_chain.sv ====
// Divider chain of a PLL synthesiser: reference, swallow/main, detector.
// Assumes prescaler output arrives as a level synchronous to clk_in.
`timescale 1ns/1ps
module sdc_divider_chain
  import sdc_pkg::*;
#(
  parameter int REF_W  = SDC_REF_W,
  parameter int MAIN_W = SDC_MAIN_W,
  parameter int SWAL_W = SDC_SWAL_W
)
(
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // Serial port from the controller
  input  wire logic        ser_clk_in,
  input  wire logic        ser_data_in,
  input  wire logic        ser_enable_in,
  // Prescaler output and modulus control
  input  wire logic        prescaler_in,
  output logic             modulus_select_n_out,
  // Phase detector outputs
  output logic             coarse_up_out,
  output logic             coarse_error_out,
  output logic             coarse_error_oe_out,
  output logic             ramp_run_out,
  output logic             fine_sample_out,
  output logic             lock_flag_n_out,
  output logic             ref_div_out,
  output logic             vco_div_out
);

  // The serial frame fixes all three widths; anything else is refused at elaboration
  if (REF_W != SDC_REF_W || MAIN_W != SDC_MAIN_W || SWAL_W != SDC_SWAL_W)
  begin : g_width_check
    $error("sdc_divider_chain: widths fixed by serial frame");
  end

  sdc_ratio_s ratio;
  logic       reload;

  sdc_serial_load u_load (
    .clk_in        (clk_in),
    .rst_in        (rst_in),
    .ser_clk_in    (ser_clk_in),
    .ser_data_in   (ser_data_in),
    .ser_enable_in (ser_enable_in),
    .ratio_out     (ratio),
    .reload_out    (reload)
  );

  // ----------------------------------------------------------------
  // Reference chain
  // ----------------------------------------------------------------
  logic [10:0] ref_cnt;
  logic        ref_half;
  logic        ref_edge;

  // Below-minimum ratios are clamped; the device does not serve them
  wire [10:0] ref_eff  = (ratio.ref_ratio < SDC_REF_MIN) ? SDC_REF_MIN
                                                          : ratio.ref_ratio;
  wire        ref_tc   = ref_cnt == ref_eff - 11'h001;

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ref_cnt  <= '0;
      ref_half <= 1'b0;
      ref_edge <= 1'b0;
    end
    else if (reload)
    begin
      ref_cnt  <= '0;
      ref_half <= 1'b0;
      ref_edge <= 1'b0;
    end
    else
    begin
      ref_cnt  <= ref_tc ? '0 : ref_cnt + 11'h001;
      if (ref_tc)
        ref_half <= ~ref_half;
      ref_edge <= ref_tc & ref_half;
    end
  end

  // ----------------------------------------------------------------
  // VCO chain: swallow and main counters over the prescaler
  // ----------------------------------------------------------------
  logic [9:0] main_cnt;
  logic [6:0] swal_cnt;
  logic       pre_d;
  logic       vco_edge;
  sdc_mod_e   mod_state;

  wire [9:0] main_eff  = (ratio.main_ratio < SDC_MAIN_MIN) ? SDC_MAIN_MIN
                                                            : ratio.main_ratio;
  wire       pre_rise  = prescaler_in & ~pre_d;
  wire       main_tc   = pre_rise && main_cnt == main_eff - 10'h001;
  wire       swal_done = swal_cnt == ratio.swal_ratio;

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      main_cnt  <= '0;
      swal_cnt  <= '0;
      pre_d     <= 1'b0;
      vco_edge  <= 1'b0;
      mod_state <= SDC_MOD_LOW;
    end
    else
    begin
      pre_d    <= prescaler_in;
      vco_edge <= main_tc;
      if (reload)
      begin
        main_cnt  <= '0;
        swal_cnt  <= '0;
        mod_state <= SDC_MOD_LOW;
      end
      else if (main_tc)
      begin
        main_cnt  <= '0;
        swal_cnt  <= '0;
        mod_state <= SDC_MOD_LOW;
      end
      else if (pre_rise)
      begin
        main_cnt <= main_cnt + 10'h001;
        // A pulse meeting a finished swallow count must not count it again
        if (mod_state == SDC_MOD_LOW && !swal_done)
        begin
          swal_cnt <= swal_cnt + 7'h01;
          if (swal_cnt + 7'h01 == ratio.swal_ratio)
            mod_state <= SDC_MOD_HIGH;
        end
        else if (mod_state == SDC_MOD_LOW)
          mod_state <= SDC_MOD_HIGH;
      end
      else if (mod_state == SDC_MOD_LOW && swal_done)
        mod_state <= SDC_MOD_HIGH;
    end
  end

  assign modulus_select_n_out = mod_state == SDC_MOD_HIGH;

  // ----------------------------------------------------------------
  // Phase/frequency detector, window and lock
  // ----------------------------------------------------------------
  logic       pfd_up;
  logic       pfd_dn;
  logic [3:0] err_cnt;
  logic       err_small;
  logic       ramp_run;
  logic       fine_sample;
  logic       ref_div;
  logic       vco_div;

  wire both = (pfd_up | ref_edge) & (pfd_dn | vco_edge);

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pfd_up      <= 1'b0;
      pfd_dn      <= 1'b0;
      err_cnt     <= '0;
      err_small   <= 1'b0;
      ramp_run    <= 1'b0;
      fine_sample <= 1'b0;
      ref_div     <= 1'b0;
      vco_div     <= 1'b0;
    end
    else if (reload)
    begin
      pfd_up    <= 1'b0;
      pfd_dn    <= 1'b0;
      err_cnt   <= '0;
      err_small <= 1'b0;
      ramp_run  <= 1'b0;
    end
    else
    begin
      ref_div     <= ref_half;
      vco_div     <= mod_state == SDC_MOD_LOW;
      // Edge-pair comparison, once per period
      pfd_up      <= (pfd_up | ref_edge) & ~both;
      pfd_dn      <= (pfd_dn | vco_edge) & ~both;
      // Ramp starts on the reference edge and stops on the VCO edge
      ramp_run    <= (ramp_run | ref_edge) & ~vco_edge;
      fine_sample <= ref_edge;
      if (pfd_up | pfd_dn)
        err_cnt <= (err_cnt == 4'hf) ? err_cnt : err_cnt + 4'h1;
      else
        err_cnt <= '0;
      if (both)
        err_small <= err_cnt < SDC_WINDOW_CYC;
    end
  end

  assign coarse_up_out       = pfd_up;
  assign coarse_error_out    = pfd_up;
  assign coarse_error_oe_out = (pfd_up | pfd_dn) & ~err_small;
  assign lock_flag_n_out     = ~err_small;
  assign ramp_run_out        = ramp_run;
  assign fine_sample_out     = fine_sample;
  assign ref_div_out         = ref_div;
  assign vco_div_out         = vco_div;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_cycle_end;
    main_tc;
  endsequence

  a_modsel_restart: assert property (@(posedge clk_in) disable iff (rst_in)
    s_cycle_end |=> !modulus_select_n_out || ratio.swal_ratio == 7'h00)
    else $error("modulus select not low after cycle end");

  a_reload_clears: assert property (@(posedge clk_in) disable iff (rst_in)
    reload |=> main_cnt == 10'h000 && ref_cnt == 11'h000)
    else $error("counters not cleared on reload");

  a_lock_float: assert property (@(posedge clk_in) disable iff (rst_in)
    !lock_flag_n_out |-> !coarse_error_oe_out)
    else $error("lock asserted while coarse output drives");

  a_lock_update: assert property (@(posedge clk_in) disable iff (rst_in)
    $changed(lock_flag_n_out) |-> $past(both) || $past(reload))
    else $error("lock flag moved without an edge pair");

  a_ref_edge_rate: assert property (@(posedge clk_in) disable iff (rst_in)
    ref_edge |=> !ref_edge [*5])
    else $error("reference edge faster than divide by six");

  a_ref_range: assert property (@(posedge clk_in) disable iff (rst_in)
    ref_cnt < ref_eff)
    else $error("reference counter beyond ratio");

  a_main_range: assert property (@(posedge clk_in) disable iff (rst_in)
    main_cnt < main_eff)
    else $error("main counter beyond ratio");

  a_swal_hold: assert property (@(posedge clk_in) disable iff (rst_in)
    modulus_select_n_out && !main_tc && !reload |=> $stable(swal_cnt))
    else $error("swallow counter moved in high phase");

  a_ramp_sample: assert property (@(posedge clk_in) disable iff (rst_in)
    ref_edge && !reload |=> fine_sample_out)
    else $error("fine sample missed reference edge");

  a_pfd_clear: assert property (@(posedge clk_in) disable iff (rst_in)
    both && !reload |=> !(pfd_up && pfd_dn))
    else $error("detector not cleared after edge pair");

endmodule

// ==== shared/sdc_pkg.sv ====
// Constants and carrier types for the synthesiser divider chain.
// Assumes one system clock; divider inputs arrive as synchronous levels.
package sdc_pkg;

  // ----------------------------------------------------------------
  // Word widths and limits
  // ----------------------------------------------------------------
  localparam int          SDC_REF_W     = 11;
  localparam int          SDC_MAIN_W    = 10;
  localparam int          SDC_SWAL_W    = 7;
  localparam int          SDC_FRAME_LEN = 28;
  localparam logic [10:0] SDC_REF_MIN   = 11'h003;
  localparam logic [9:0]  SDC_MAIN_MIN  = 10'h008;
  localparam logic [4:0]  SDC_BITS_FULL = 5'h1c;

  // ----------------------------------------------------------------
  // Reset values of the counter latches
  // ----------------------------------------------------------------
  localparam logic [10:0] SDC_REF_RST   = 11'h003;
  localparam logic [9:0]  SDC_MAIN_RST  = 10'h008;
  localparam logic [6:0]  SDC_SWAL_RST  = 7'h00;

  // Fine window width in clock cycles
  localparam logic [3:0]  SDC_WINDOW_CYC = 4'h4;

  typedef struct packed {
    logic [10:0] ref_ratio;
    logic [9:0]  main_ratio;
    logic [6:0]  swal_ratio;
  } sdc_ratio_s;

  typedef enum logic {SDC_MOD_LOW, SDC_MOD_HIGH} sdc_mod_e;

endpackage

// ==== hdl/sdc_serial_load.sv ====
// Serial loader: shift register, edge count and counter latches.
// Assumes serial clock, data and enable are synchronous levels.
`timescale 1ns/1ps
module sdc_serial_load
  import sdc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // Serial port
  input  wire logic        ser_clk_in,
  input  wire logic        ser_data_in,
  input  wire logic        ser_enable_in,
  // Latched ratios
  output sdc_ratio_s       ratio_out,
  output logic             reload_out
);

  logic [27:0] shift;
  logic [4:0]  edge_cnt;
  logic        ser_clk_d;
  logic        enable_d;
  sdc_ratio_s  ratio;

  wire fall_clk   = ser_clk_d & ~ser_clk_in & ser_enable_in;
  wire fall_en    = enable_d & ~ser_enable_in;
  wire full_frame = edge_cnt >= SDC_BITS_FULL;
  wire [4:0] next_edge_cnt = full_frame ? edge_cnt : edge_cnt + 5'h01;

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      shift     <= '0;
      edge_cnt  <= '0;
      ser_clk_d <= 1'b0;
      enable_d  <= 1'b0;
      ratio     <= '{SDC_REF_RST, SDC_MAIN_RST, SDC_SWAL_RST};
    end
    else
    begin
      ser_clk_d <= ser_clk_in;
      enable_d  <= ser_enable_in;
      if (fall_clk)
      begin
        shift    <= {shift[26:0], ser_data_in};
        edge_cnt <= next_edge_cnt;
      end
      if (fall_en)
      begin
        edge_cnt <= '0;
        if (full_frame)
          ratio <= '{shift[10:0], shift[20:11], shift[27:21]};
        else
        begin
          // Short frame: reference word is left alone against clock glitches
          ratio.main_ratio <= shift[9:0];
          ratio.swal_ratio <= shift[16:10];
        end
      end
    end
  end

  assign ratio_out  = ratio;
  assign reload_out = fall_en;

  a_short_keeps_ref: assert property (@(posedge clk_in) disable iff (rst_in)
    fall_en && !full_frame |=> $stable(ratio.ref_ratio))
    else $error("reference latch changed on a short frame");

endmodule

// ==== bench/sdc_partner.sv ====
// Far side: serial controller and 4/5-style dual-modulus prescaler.
// Assumes the bench calls load() and this model alone drives these pins.
`timescale 1ns/1ps
module sdc_partner
  import sdc_pkg::*;
#(
  parameter int PRESC_P = 4
)
(
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_in,
  // Prescaler
  input  wire logic modulus_select_n_in,
  output logic      prescaler_out,
  // Serial port
  output logic      ser_clk_out,
  output logic      ser_data_out,
  output logic      ser_enable_out
);
  int cnt;

  initial
  begin
    ser_clk_out    = 1'b0;
    ser_data_out   = 1'b0;
    ser_enable_out = 1'b0;
  end

  // One-cycle pulse; low select divides by P+1, high by P
  always @(negedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cnt           <= 0;
      prescaler_out <= 1'b0;
    end
    else if (cnt == 0)
    begin
      prescaler_out <= 1'b1;
      cnt           <= modulus_select_n_in ? PRESC_P - 1 : PRESC_P;
    end
    else
    begin
      prescaler_out <= 1'b0;
      cnt           <= cnt - 1;
    end
  end

  task automatic hold2();
    repeat (2) @(negedge clk_in);
  endtask

  // Levels held two cycles so the sampled serial clock shows each fall
  task automatic load(input logic [10:0] r, input logic [9:0] m, input logic [6:0] a,
                      input logic full);
    logic [27:0] w;
    int          n;
    w = {a, m, r};
    n = full ? 28 : 17;
    @(negedge clk_in);
    ser_enable_out = 1'b1;
    hold2();
    for (int i = 27; i > 27 - n; i--)
    begin
      ser_data_out = w[i];
      ser_clk_out  = 1'b1;
      hold2();
      ser_clk_out  = 1'b0;
      hold2();
    end
    ser_enable_out = 1'b0;
    ser_data_out   = ~ser_data_out;
    hold2();
  endtask
endmodule

// ==== bench/synth_divider_chain_test.sv ====
// Self-checking bench: loads ratios, measures divider outputs and lock.
// Assumes a 20 MHz clock and the partner's prescaler pair P=4.
`timescale 1ns/1ps
module synth_divider_chain_test;
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        s_clk, s_dat, s_en, presc, mod_n, c_oe, fsmp, lock_n, ref_div, vco_div;
  logic        c_up, c_err, ramp;
  int          bad_count = 0;
  int          n_compared = 0;
  int          seed = 65;
  logic [31:0] notes[$];
  bit          busy = 1'b0;

  always #25 clk_in = ~clk_in;

  sdc_divider_chain dut (.clk_in(clk_in), .rst_in(rst_in), .ser_clk_in(s_clk),
    .ser_data_in(s_dat), .ser_enable_in(s_en), .prescaler_in(presc),
    .modulus_select_n_out(mod_n), .coarse_up_out(c_up), .coarse_error_out(c_err),
    .coarse_error_oe_out(c_oe), .ramp_run_out(ramp), .fine_sample_out(fsmp),
    .lock_flag_n_out(lock_n), .ref_div_out(ref_div), .vco_div_out(vco_div));

  sdc_partner part (.clk_in(clk_in), .rst_in(rst_in), .modulus_select_n_in(mod_n),
    .prescaler_out(presc), .ser_clk_out(s_clk), .ser_data_out(s_dat),
    .ser_enable_out(s_en));

  // ----------------------------------------------------------------
  // Monitor
  // ----------------------------------------------------------------
  function automatic logic pick(input logic w);
    return w ? vco_div : ref_div;
  endfunction

  // Edges to the next rise; modulus taken from before each edge
  task automatic to_rise(input logic w, output int n, lo, tot, fin);
    logic prev, pm;
    n = 0;
    lo = 0;
    tot = 0;
    fin = 0;
    prev = 1'b1;
    pm = mod_n;
    while (n < 20000 && !(prev === 1'b0 && pick(w) === 1'b1))
    begin
      prev = pick(w);
      @(posedge clk_in);
      #1;
      n++;
      tot += (presc === 1'b1);
      lo += (presc === 1'b1 && pm === 1'b0);
      fin += (fsmp === 1'b1);
      pm = mod_n;
    end
  endtask

  initial
  begin
    logic [31:0] e, got;
    int          n, lo, tot, fin;
    forever
    begin
      wait (notes.size() > 0);
      busy = 1'b1;
      e = notes.pop_front();
      if (e[29] && e[28])
      begin
        // Window flags: lock seen, coarse drives, drives other than up, ramp runs
        got = 32'h0;
        repeat (100)
        begin
          @(posedge clk_in);
          #1;
          got[3] = got[3] | (lock_n !== 1'b1);
          got[2] = got[2] | (c_oe === 1'b1);
          got[1] = got[1] | (c_oe !== 1'b0 && (c_err !== 1'b1 || c_up !== 1'b1));
          got[0] = got[0] | (ramp === 1'b1);
        end
      end
      else if (e[29])
      begin
        repeat (8000) if (lock_n !== 1'b0)
        begin
          @(posedge clk_in);
          #1;
        end
        got = {30'h0, lock_n === 1'b0, c_oe};
      end
      else
      begin
        to_rise(e[28], n, lo, tot, fin);
        to_rise(e[28], n, lo, tot, fin);
        got = e[28] ? 32'((lo << 16) | tot) : 32'((fin << 16) | n);
      end
      got[31:28] = e[31:28];
      n_compared++;
      if (got !== e)
      begin
        bad_count++;
        $display("BAD t=%0t exp=%h got=%h", $time, e, got);
      end
      busy = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Driver
  // ----------------------------------------------------------------
  task automatic note(input logic [3:0] k, input logic [27:0] v);
    notes.push_back({k, v});
  endtask

  task automatic settle(input string name);
    wait (notes.size() == 0 && !busy);
    $display("Test %s done at %0t", name, $time);
  endtask

  task automatic run(input logic [10:0] r, input logic [9:0] m, input logic [6:0] a,
                     input logic full, input logic [10:0] rexp, input string name);
    part.load(r, m, a, full);
    note(4'h0, 28'h10000 | 28'({rexp, 1'b0}));
    note(4'h1, 28'({a, 16'h0}) | 28'(m));
    settle(name);
  endtask

  // Release reset after the given falling edges and check the reset ratios
  task automatic reset_check(input int cycles);
    repeat (cycles) @(negedge clk_in);
    rst_in = 1'b0;
    @(negedge clk_in);
    note(4'h0, 28'h10006);
    note(4'h1, 28'h8);
    settle("reset");
  endtask

  task automatic end_of_test();
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    repeat (90000) @(posedge clk_in);
    bad_count++;
    $display("BAD t=%0t exp=%h got=%h", $time, 1'b1, 1'b0);
    end_of_test();
  end

  initial
  begin
    logic [10:0] r;
    logic [9:0]  m;
    logic [6:0]  a;
    reset_check(12);
    run(11'h003, 10'h008, 7'h00, 1'b1, 11'h003, "min");
    run(11'h7ff, 10'h3ff, 7'h7f, 1'b1, 11'h7ff, "max");
    run(11'h190, 10'h157, 7'h30, 1'b1, 11'h190, "mid");
    run(11'h005, 10'h014, 7'h05, 1'b0, 11'h190, "short");
    repeat (2)
    begin
      r = 11'(3 + {$random(seed)} % 400);
      m = 10'(8 + {$random(seed)} % 300);
      a = 7'({$random(seed)} % 128);
      // Swallow equal to main keeps modulus low all cycle and vco_div_out flat
      if (10'(a) >= m)
        a = 7'(m - 10'h001);
      run(r, m, a, 1'b1, r, "random");
    end
    // Reset in mid-run must bring the latches back to their reset ratios
    @(negedge clk_in);
    rst_in = 1'b1;
    reset_check(2);
    // Main cycle 40 against reference 32: error grows, no lock in the window
    part.load(11'h010, 10'h00a, 7'h00, 1'b1);
    note(4'h3, 28'h5);
    settle("drift");
    // Matched rates, N = 8 * 4 = 2 * 16, and N above P*P-P
    part.load(11'h010, 10'h008, 7'h00, 1'b1);
    note(4'h2, 28'h2);
    settle("lock");
    end_of_test();
  end
endmodule
